// >>> hw/chs_pkg.sv
// constants and types shared by the charger state and status logic
package chs_pkg;

	// ----------------------------------------------------------------
	// clock and documented times
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int BAD_BATT_TIME_MIN = 30;
	localparam int SAFETY_TIME_H = 4;
	localparam int FILTER_TIME_US = 1700;
	localparam int CARRIER_HZ = 35_000;
	localparam int SLOW_BLINK_MHZ = 1500;
	localparam int FAST_BLINK_MHZ = 6100;

	// ----------------------------------------------------------------
	// derived counts
	// ----------------------------------------------------------------
	localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
	localparam int BAD_BATT_TICKS = BAD_BATT_TIME_MIN * 60 * MS_PER_S;
	localparam int SAFETY_TICKS = SAFETY_TIME_H * 3600 * MS_PER_S;
	localparam int FILTER_CYCLES = (FILTER_TIME_US * (CLK_HZ / MS_PER_S) + 999) / 1000;
	localparam int CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
	localparam int SLOW_HALF_CARRIERS = (CARRIER_HZ * MS_PER_S) / (2 * SLOW_BLINK_MHZ);
	localparam int FAST_HALF_CARRIERS = (CARRIER_HZ * MS_PER_S) / (2 * FAST_BLINK_MHZ);

	// ----------------------------------------------------------------
	// duty values in sixteenths of a carrier period (pin pulled low)
	// ----------------------------------------------------------------
	localparam int DUTY_DEN = 16;
	localparam int SLOW_DUTY_LO = 1;
	localparam int SLOW_DUTY_HI = 15;
	localparam int FAST_DUTY_LO = 2;
	localparam int FAST_DUTY_HI = 14;

	// ----------------------------------------------------------------
	// current level and blink pattern codes
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_OFF = 2'h0;
	localparam logic [1:0] LVL_TENTH = 2'h1;
	localparam logic [1:0] LVL_FIFTH = 2'h2;
	localparam logic [1:0] LVL_FULL = 2'h3;
	localparam logic [1:0] PAT_NONE = 2'h0;
	localparam logic [1:0] PAT_SLOW = 2'h1;
	localparam logic [1:0] PAT_FAST = 2'h2;

	// synchroniser width and reset value; lockout bit resets set so that
	// the charger cannot start before the first real samples arrive
	localparam int SYNC_W = 9;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 9'h100;

	typedef enum logic [1:0] {
		st_off,
		st_charge,
		st_bad,
		st_done
	} chs_state_t;

endpackage : chs_pkg

// >>> hw/chs_blink.sv
// 35 kHz carrier with duty modulated between two values at a blink rate
`timescale 1ns/10ps
module chs_blink #(
	parameter int CARRIER_CYCLES = chs_pkg::CARRIER_CYCLES,
	parameter int SLOW_HALF = chs_pkg::SLOW_HALF_CARRIERS,
	parameter int FAST_HALF = chs_pkg::FAST_HALF_CARRIERS
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [1:0] pattern_in,
	output logic drive_low_out
);
	import chs_pkg::*;

	localparam int CW = $clog2(CARRIER_CYCLES + 1);
	localparam int BW = $clog2(((SLOW_HALF > FAST_HALF) ? SLOW_HALF : FAST_HALF) + 1);

	// ----------------------------------------------------------------
	// duty threshold in clock cycles
	// ----------------------------------------------------------------
	function automatic logic [CW-1:0] duty_cycles(input int sixteenths);
		duty_cycles = CW'((CARRIER_CYCLES * sixteenths) / DUTY_DEN);
	endfunction : duty_cycles

	logic [CW-1:0] car_reg;
	logic [BW-1:0] blk_reg;
	logic phase_reg;
	logic active_w;
	logic car_wrap_w;
	logic half_w;
	logic [BW-1:0] half_len_w;
	logic [CW-1:0] thresh_w;

	// pattern selection and wrap points
	assign active_w = (pattern_in != PAT_NONE);
	assign car_wrap_w = (car_reg == CW'(CARRIER_CYCLES - 1));
	assign half_len_w = (pattern_in == PAT_FAST) ? BW'(FAST_HALF) : BW'(SLOW_HALF);
	assign half_w = car_wrap_w && (blk_reg == half_len_w - BW'(1));
	assign thresh_w = (pattern_in == PAT_FAST)
		? (phase_reg ? duty_cycles(FAST_DUTY_HI) : duty_cycles(FAST_DUTY_LO))
		: (phase_reg ? duty_cycles(SLOW_DUTY_HI) : duty_cycles(SLOW_DUTY_LO));

	// carrier counter, restarts whenever no pattern is shown
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			car_reg <= '0;
		else if (!active_w || car_wrap_w)
			car_reg <= '0;
		else
			car_reg <= car_reg + CW'(1);
	end

	// blink half-period counter in carrier periods, phase toggles each half
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			blk_reg <= '0;
			phase_reg <= 1'b0;
		end
		else if (!active_w)
		begin
			blk_reg <= '0;
			phase_reg <= 1'b0;
		end
		else if (half_w)
		begin
			blk_reg <= '0;
			phase_reg <= ~phase_reg;
		end
		else if (car_wrap_w)
			blk_reg <= blk_reg + BW'(1);
	end

	// pin low for the first part of each carrier period
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			drive_low_out <= 1'b0;
		else
			drive_low_out <= active_w && (car_reg < thresh_w);
	end

endmodule : chs_blink

// >>> hw/chs_charger.sv
// charger sequencing, timers and open-drain status pin encoding
// How it works
// - disable charger while input undervoltage lockout
// - disable charger on differential undervoltage lockout
// - suspend input disables charging
// - below trickle threshold: trickle, tenth current
// - above trickle: constant current, then voltage
// - half hour in trickle latches bad battery
// - rising above trickle resumes charging
// - latched, falls again without recharge: defective
// - latch cleared by power cycle or suspend
// - safety timer starts above recharge in CV
// - safety timer expiry terminates charging
// - terminated: restart when below recharge threshold
// - below recharge while timing resets timer
// - below recharge only after filter time
// - input lockout or suspend cycle restarts everything
// - high select full current, else one fifth
// - status pin low throughout normal charging
// - status released below tenth current
// - faults blink only if not yet released
// - thermistor fault: slow blink, 1/16 15/16
// - bad battery: fast blink, 2/16 14/16
// - thermistor fault pauses charging
// - thermistor fault pauses safety timer
`timescale 1ns/10ps
module chs_charger #(
	parameter int TICK_CYCLES = chs_pkg::TICK_CYCLES,
	parameter int BAD_BATT_TICKS = chs_pkg::BAD_BATT_TICKS,
	parameter int SAFETY_TICKS = chs_pkg::SAFETY_TICKS,
	parameter int FILTER_CYCLES = chs_pkg::FILTER_CYCLES,
	parameter int CARRIER_CYCLES = chs_pkg::CARRIER_CYCLES,
	parameter int SLOW_HALF = chs_pkg::SLOW_HALF_CARRIERS,
	parameter int FAST_HALF = chs_pkg::FAST_HALF_CARRIERS
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic input_undervoltage_lockout_in,
	input wire logic differential_undervoltage_lockout_in,
	input wire logic charge_suspend_input_in,
	input wire logic below_trickle_threshold_in,
	input wire logic below_recharge_threshold_in,
	input wire logic constant_voltage_in,
	input wire logic below_tenth_current_in,
	input wire logic thermistor_fault_in,
	input wire logic high_current_select_in,
	input wire logic charge_status_output_in,
	output logic charge_status_output_out,
	output logic charge_status_output_oe_n_out,
	output logic charger_enable_out,
	output logic [1:0] current_level_out,
	output logic [1:0] charge_state_out,
	output logic bad_battery_out,
	output logic safety_running_out
);
	import chs_pkg::*;

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int BBW = $clog2(BAD_BATT_TICKS + 1);
	localparam int SFW = $clog2(SAFETY_TICKS + 1);
	localparam int FW = $clog2(FILTER_CYCLES + 1);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	logic [SYNC_W-1:0] raw_w;

	assign raw_w = {input_undervoltage_lockout_in, differential_undervoltage_lockout_in,
		charge_suspend_input_in, below_trickle_threshold_in, below_recharge_threshold_in,
		constant_voltage_in, below_tenth_current_in, thermistor_fault_in,
		high_current_select_in};

	// two flops for every comparator flag
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			meta_reg <= SYNC_RESET;
			sync_reg <= SYNC_RESET;
		end
		else
		begin
			meta_reg <= raw_w;
			sync_reg <= meta_reg;
		end
	end

	logic input_undervoltage_lockout_w;
	logic differential_undervoltage_lockout_w;
	logic charge_suspend_input_w;
	logic trkl_w;
	logic rech_w;
	logic cv_w;
	logic tenth_w;
	logic ntc_w;
	logic high_current_select_w;

	// synchronised flag names
	assign input_undervoltage_lockout_w = sync_reg[8];
	assign differential_undervoltage_lockout_w = sync_reg[7];
	assign charge_suspend_input_w = sync_reg[6];
	assign trkl_w = sync_reg[5];
	assign rech_w = sync_reg[4];
	assign cv_w = sync_reg[3];
	assign tenth_w = sync_reg[2];
	assign ntc_w = sync_reg[1];
	assign high_current_select_w = sync_reg[0];

	// ----------------------------------------------------------------
	// millisecond prescaler
	// ----------------------------------------------------------------
	logic [TW-1:0] tick_cnt_reg;
	logic tick_w;

	assign tick_w = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

	// free-running divider for the long timers
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			tick_cnt_reg <= '0;
		else if (tick_w)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + TW'(1);
	end

	// ----------------------------------------------------------------
	// recharge threshold filter
	// ----------------------------------------------------------------
	logic [FW-1:0] filt_cnt_reg;
	logic rech_low_w;

	assign rech_low_w = (filt_cnt_reg == FW'(FILTER_CYCLES));

	// counts while below, saturates, clears on any excursion above
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			filt_cnt_reg <= '0;
		else if (!rech_w)
			filt_cnt_reg <= '0;
		else if (!rech_low_w)
			filt_cnt_reg <= filt_cnt_reg + FW'(1);
	end

	// ----------------------------------------------------------------
	// state machine decode
	// ----------------------------------------------------------------
	chs_state_t state_reg;
	chs_state_t state_next;
	logic bad_latch_reg;
	logic rose_reg;
	logic released_reg;
	logic safe_run_reg;
	logic [BBW-1:0] bad_cnt_reg;
	logic [SFW-1:0] safe_cnt_reg;

	logic disabled_w;
	logic start_w;
	logic charging_w;
	logic bad_count_w;
	logic bad_expire_w;
	logic defective_w;
	logic safe_start_w;
	logic safe_expire_w;
	logic safe_clear_w;
	logic latch_clear_w;

	assign disabled_w = input_undervoltage_lockout_w || differential_undervoltage_lockout_w || charge_suspend_input_w;
	assign start_w = (state_reg == st_off) && !disabled_w;
	assign charging_w = (state_reg == st_charge);
	assign bad_count_w = charging_w && trkl_w && !ntc_w;
	assign bad_expire_w = bad_count_w && tick_w
		&& (bad_cnt_reg == BBW'(BAD_BATT_TICKS - 1));
	assign defective_w = charging_w && trkl_w && bad_latch_reg && !rose_reg;
	assign safe_start_w = charging_w && !rech_w && cv_w;
	assign safe_expire_w = safe_run_reg && !ntc_w && tick_w
		&& (safe_cnt_reg == SFW'(SAFETY_TICKS - 1));
	assign safe_clear_w = start_w || (safe_run_reg && rech_low_w);
	assign latch_clear_w = input_undervoltage_lockout_w || charge_suspend_input_w;

	// next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			st_off:
				if (!disabled_w)
					state_next = st_charge;
			st_charge:
				if (defective_w || bad_expire_w)
					state_next = st_bad;
				else if (safe_expire_w)
					state_next = st_done;
			st_bad:
				if (!trkl_w)
					state_next = st_charge;
			st_done:
				if (rech_low_w)
					state_next = st_charge;
			default:
				state_next = st_off;
		endcase
		if (disabled_w)
			state_next = st_off;
	end

	// state register
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			state_reg <= st_off;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------------------------------
	// bad-battery latch and half-hour timer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			bad_cnt_reg <= '0;
		else if (!charging_w || !trkl_w || bad_expire_w)
			bad_cnt_reg <= '0;
		else if (bad_count_w && tick_w)
			bad_cnt_reg <= bad_cnt_reg + BBW'(1);
	end

	// latch set wins over clear; rose marks a trip past recharge
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bad_latch_reg <= 1'b0;
			rose_reg <= 1'b0;
		end
		else if (bad_expire_w)
		begin
			bad_latch_reg <= 1'b1;
			rose_reg <= 1'b0;
		end
		else if (latch_clear_w)
		begin
			bad_latch_reg <= 1'b0;
			rose_reg <= 1'b0;
		end
		else if (!rech_w)
			rose_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// four-hour safety timer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			safe_run_reg <= 1'b0;
			safe_cnt_reg <= '0;
		end
		else if (safe_clear_w || safe_expire_w || disabled_w)
		begin
			safe_run_reg <= 1'b0;
			safe_cnt_reg <= '0;
		end
		else if (safe_start_w && !safe_run_reg)
			safe_run_reg <= 1'b1;
		else if (safe_run_reg && !ntc_w && tick_w)
			safe_cnt_reg <= safe_cnt_reg + SFW'(1);
	end

	// ----------------------------------------------------------------
	// status pin release flag
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			released_reg <= 1'b1;
		else if (state_next == st_charge && state_reg != st_charge
			&& state_reg != st_bad)
			released_reg <= 1'b0;
		else if (state_reg == st_off || state_reg == st_done)
			released_reg <= 1'b1;
		else if (charging_w && !trkl_w && tenth_w && !ntc_w)
			released_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// current command and pin encoding
	// ----------------------------------------------------------------
	logic enable_w;
	logic [1:0] level_w;
	logic [1:0] pattern_w;
	logic blink_low_w;
	logic drive_low_w;

	assign enable_w = charging_w && !ntc_w;
	assign level_w = !enable_w ? LVL_OFF
		: trkl_w ? LVL_TENTH
		: high_current_select_w ? LVL_FULL : LVL_FIFTH;
	assign pattern_w = released_reg ? PAT_NONE
		: (state_reg == st_bad) ? PAT_FAST
		: (charging_w && ntc_w) ? PAT_SLOW : PAT_NONE;
	assign drive_low_w = (pattern_w != PAT_NONE) ? blink_low_w
		: (enable_w && !released_reg);

	// carrier and blink generator
	chs_blink #(
		.CARRIER_CYCLES(CARRIER_CYCLES),
		.SLOW_HALF(SLOW_HALF),
		.FAST_HALF(FAST_HALF)
	) u_blink (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.pattern_in(pattern_w),
		.drive_low_out(blink_low_w)
	);

	// registered outputs
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			charge_status_output_out <= 1'b0;
			charge_status_output_oe_n_out <= 1'b1;
			charger_enable_out <= 1'b0;
			current_level_out <= LVL_OFF;
			charge_state_out <= 2'h0;
			bad_battery_out <= 1'b0;
			safety_running_out <= 1'b0;
		end
		else
		begin
			charge_status_output_out <= 1'b0; // open drain only pulls low
			charge_status_output_oe_n_out <= ~drive_low_w;
			charger_enable_out <= enable_w;
			current_level_out <= level_w;
			charge_state_out <= state_reg;
			bad_battery_out <= bad_latch_reg;
			safety_running_out <= safe_run_reg;
		end
	end

endmodule : chs_charger

// >>> bench/chs_charger_asserts.sv
// concurrent checks on the charger state and status ports
`timescale 1ns/10ps
module chs_charger_asserts #(
	parameter int FILTER_CYCLES = 10
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic input_undervoltage_lockout_in,
	input wire logic differential_undervoltage_lockout_in,
	input wire logic charge_suspend_input_in,
	input wire logic below_trickle_threshold_in,
	input wire logic below_recharge_threshold_in,
	input wire logic constant_voltage_in,
	input wire logic thermistor_fault_in,
	input wire logic high_current_select_in,
	input wire logic charge_status_output_oe_n_out,
	input wire logic charger_enable_out,
	input wire logic [1:0] current_level_out,
	input wire logic [1:0] charge_state_out,
	input wire logic bad_battery_out
);
	import chs_pkg::*;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// ----------------------------------------------------------------
	// helper: length of the raw below-recharge run
	// ----------------------------------------------------------------
	logic [15:0] lo_run_reg;
	logic seen_long_reg;
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			lo_run_reg <= 16'h0000;
			seen_long_reg <= 1'b0;
		end
		else
		begin
			lo_run_reg <= below_recharge_threshold_in ? lo_run_reg + 16'h0001 : 16'h0000;
			seen_long_reg <= (charge_state_out == 2'h3)
				&& (seen_long_reg || lo_run_reg >= FILTER_CYCLES);
		end
	end
	// a flag held long enough to pass the synchroniser
	sequence s_held(sig);
		sig [*6];
	endsequence
	chk_lockout_blocks_charge: assert property (s_held(input_undervoltage_lockout_in)
		|-> !charger_enable_out) else $error("charger enabled during input lockout");
	chk_margin_blocks_charge: assert property (s_held(differential_undervoltage_lockout_in)
		|-> !charger_enable_out) else $error("charger enabled inside supply margin");
	chk_suspend_blocks_charge: assert property (s_held(charge_suspend_input_in)
		|-> !charger_enable_out) else $error("charger enabled while suspended");
	chk_trickle_tenth_level: assert property (s_held(below_trickle_threshold_in)
		##0 charger_enable_out |-> current_level_out == LVL_TENTH)
		else $error("trickle current not one tenth");
	chk_high_select_full: assert property (s_held(high_current_select_in
		&& !below_trickle_threshold_in && !constant_voltage_in) ##0 charger_enable_out
		|-> current_level_out == LVL_FULL) else $error("high select not full current");
	chk_done_no_current: assert property ((charge_state_out == 2'h3) [*2]
		|-> !charger_enable_out && charge_status_output_oe_n_out)
		else $error("current or pin low after timer end");
	chk_bad_stops_charge: assert property ((charge_state_out == 2'h2) [*2]
		|-> !charger_enable_out && bad_battery_out) else $error("bad battery still charging");
	chk_hot_cold_pause: assert property (s_held(thermistor_fault_in)
		|-> !charger_enable_out) else $error("charging during temperature fault");
	chk_recharge_filter_time: assert property (charge_state_out == 2'h1
		&& $past(charge_state_out) == 2'h3 |-> seen_long_reg || lo_run_reg >= FILTER_CYCLES)
		else $error("recharge started on a short excursion");
endmodule : chs_charger_asserts
bind chs_charger chs_charger_asserts #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (
	.ref_clk_in(ref_clk_in),
	.resetn_in(resetn_in),
	.input_undervoltage_lockout_in(input_undervoltage_lockout_in),
	.differential_undervoltage_lockout_in(differential_undervoltage_lockout_in),
	.charge_suspend_input_in(charge_suspend_input_in),
	.below_trickle_threshold_in(below_trickle_threshold_in),
	.below_recharge_threshold_in(below_recharge_threshold_in),
	.constant_voltage_in(constant_voltage_in),
	.thermistor_fault_in(thermistor_fault_in),
	.high_current_select_in(high_current_select_in),
	.charge_status_output_oe_n_out(charge_status_output_oe_n_out),
	.charger_enable_out(charger_enable_out),
	.current_level_out(current_level_out),
	.charge_state_out(charge_state_out),
	.bad_battery_out(bad_battery_out)
);

// >>> bench/chs_status_host.sv
// status pin reader measuring the pulled-low time of each carrier pulse
`timescale 1ns/10ps
module chs_status_host (
	input wire logic ref_clk_in,
	input wire logic status_pin_in,
	output logic [7:0] low_count_out
);
	logic [7:0] run_reg;
	logic prev_reg;
	// count the low run, keep it when the pin rises, drop half readings
	always_ff @(posedge ref_clk_in)
	begin
		prev_reg <= status_pin_in;
		run_reg <= status_pin_in ? 8'h00 : run_reg + 8'h01;
		if (status_pin_in && !prev_reg && run_reg != 8'h10)
			low_count_out <= run_reg;
	end
endmodule : chs_status_host

// >>> bench/chs_charger_tb.sv
// self-checking bench for the charger state and status block
`timescale 1ns/10ps
module chs_charger_tb;
	import chs_pkg::*;
	localparam int CAR = 32;
	localparam int TICK = 4;
	localparam int BBT = 5;
	localparam int SFT = 8;
	localparam int FILT = 10;
	localparam int SLOW = 4;
	localparam int FAST = 2;
	logic ref_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic lockout = 1'b1, margin = 1'b0, suspend = 1'b0, trickle = 1'b0, recharge = 1'b1;
	logic cvmode = 1'b0, tenth = 1'b0, therm = 1'b0, hisel = 1'b1;
	logic pin_data, oe_n, enable, bad, safety;
	logic [1:0] level, state;
	logic [7:0] low_cnt;
	wire status_pin = oe_n ? 1'b1 : pin_data; // pull-up on the open drain
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	// ----------------------------------------------------------------
	// design, pin reader, clock and tasks
	// ----------------------------------------------------------------
	chs_charger #(.TICK_CYCLES(TICK), .BAD_BATT_TICKS(BBT), .SAFETY_TICKS(SFT),
		.FILTER_CYCLES(FILT), .CARRIER_CYCLES(CAR), .SLOW_HALF(SLOW), .FAST_HALF(FAST)) dut (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.input_undervoltage_lockout_in(lockout), .differential_undervoltage_lockout_in(margin),
		.charge_suspend_input_in(suspend), .below_trickle_threshold_in(trickle),
		.below_recharge_threshold_in(recharge), .constant_voltage_in(cvmode),
		.below_tenth_current_in(tenth), .thermistor_fault_in(therm),
		.high_current_select_in(hisel), .charge_status_output_in(status_pin),
		.charge_status_output_out(pin_data), .charge_status_output_oe_n_out(oe_n),
		.charger_enable_out(enable), .current_level_out(level), .charge_state_out(state),
		.bad_battery_out(bad), .safety_running_out(safety));
	chs_status_host host (.ref_clk_in(ref_clk_in), .status_pin_in(status_pin),
		.low_count_out(low_cnt));
	initial
		forever #4 ref_clk_in = ~ref_clk_in;
	task automatic w(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask : w
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic check_either(input string name, input int a, input int b);
		check(name, (low_cnt === 8'(b)) ? 8'(b) : 8'(a), low_cnt);
	endtask : check_either
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// hang guard
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			wrap_up();
		end
	end
	initial
	begin
		w(20);
		resetn_in = 1'b1;
		w(3);
		check("state", 8'h00, 8'(state));
		w(5);
		check("enable", 8'h00, 8'(enable));
		check("pin", 8'h01, 8'(status_pin));
		lockout = 1'b0;
		w(8);
		check("state", 8'h01, 8'(state));
		check("pin", 8'h00, 8'(status_pin));
		check("level", 8'(LVL_FULL), 8'(level));
		hisel = 1'b0;
		w(8);
		check("level", 8'(LVL_FIFTH), 8'(level));
		hisel = 1'b1;
		margin = 1'b1;
		w(8);
		check("enable", 8'h00, 8'(enable));
		margin = 1'b0;
		suspend = 1'b1;
		w(8);
		check("enable", 8'h00, 8'(enable));
		suspend = 1'b0;
		$display("test disables finished");
		w(8);
		trickle = 1'b1;
		w(8);
		check("level", 8'(LVL_TENTH), 8'(level));
		w(32);
		check("state", 8'h02, 8'(state));
		check("bad", 8'h01, 8'(bad));
		w(200);
		check_either("fast duty", CAR * FAST_DUTY_LO / DUTY_DEN, CAR * FAST_DUTY_HI / DUTY_DEN);
		trickle = 1'b0;
		w(8);
		check("state", 8'h01, 8'(state));
		trickle = 1'b1;
		w(6);
		check("state", 8'h02, 8'(state));
		suspend = 1'b1;
		trickle = 1'b0;
		w(8);
		check("bad", 8'h00, 8'(bad));
		suspend = 1'b0;
		w(8);
		check("state", 8'h01, 8'(state));
		$display("test bad battery finished");
		therm = 1'b1;
		w(8);
		check("enable", 8'h00, 8'(enable));
		w(300);
		check_either("slow duty", CAR * SLOW_DUTY_LO / DUTY_DEN, CAR * SLOW_DUTY_HI / DUTY_DEN);
		therm = 1'b0;
		w(8);
		check("enable", 8'h01, 8'(enable));
		$display("test temperature finished");
		recharge = 1'b0;
		cvmode = 1'b1;
		w(8);
		check("safety", 8'h01, 8'(safety));
		w(40);
		check("state", 8'h03, 8'(state));
		check("enable", 8'h00, 8'(enable));
		recharge = 1'b1;
		w(5);
		recharge = 1'b0;
		w(10);
		check("state", 8'h03, 8'(state));
		recharge = 1'b1;
		w(20);
		check("state", 8'h01, 8'(state));
		recharge = 1'b0;
		w(8);
		check("safety", 8'h01, 8'(safety));
		therm = 1'b1;
		w(40);
		check("safety", 8'h01, 8'(safety));
		check("state", 8'h01, 8'(state));
		therm = 1'b0;
		recharge = 1'b1;
		w(18);
		check("safety", 8'h00, 8'(safety));
		check("state", 8'h01, 8'(state));
		cvmode = 1'b0;
		$display("test timer finished");
		tenth = 1'b1;
		w(8);
		check("pin", 8'h01, 8'(status_pin));
		therm = 1'b1;
		w(100);
		check("pin", 8'h01, 8'(status_pin));
		therm = 1'b0;
		tenth = 1'b0;
		$display("test release finished");
		wrap_up();
	end
endmodule : chs_charger_tb
